// File: hdl/expander_i2c_pkg.sv
// Shared constants, strap codes and pointer advance for the serial slave
package expander_i2c_pkg;

  // Four-state strap level as reported by the strap front end
  typedef enum logic [1:0] {
    STRAP_GND = 2'h0,
    STRAP_VDD = 2'h1,
    STRAP_SCL = 2'h2,
    STRAP_SDA = 2'h3
  } strap_e;

  localparam int         SLAVE_ADDR_W  = 7;
  localparam int         PTR_W         = 8;
  localparam int         BYTE_W        = 8;
  localparam int         WR_WORD_W     = PTR_W + BYTE_W;
  localparam int         FIFO_DEPTH    = 8;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [7:0] PTR_RESET     = 8'h00;
  localparam logic [7:0] PTR_INPUTS    = 8'h00;
  localparam logic [7:0] PTR_GRP_FIRST = 8'h10;
  localparam logic [7:0] PTR_GRP_LAST  = 8'h13;

  // Intensity group cycles, every other pointer holds still
  function automatic logic [7:0] next_ptr(input logic [7:0] ptr);
    if (ptr == PTR_GRP_LAST)
      return PTR_GRP_FIRST;
    else if (ptr >= PTR_GRP_FIRST && ptr < PTR_GRP_LAST)
      return ptr + 8'h01;
    else
      return ptr;
  endfunction : next_ptr

endpackage : expander_i2c_pkg

// File: hdl/i2c_pointer_slave.sv
// Serial slave with stored register pointer and grouped auto-increment
// What this block does
// - First byte after write address loads pointer
// - Stored pointer selects register for next data
// - Stop after command byte only keeps pointer
// - Upper address bits from high, mid and low straps
// - Lower address bits from straps supply level
// - First data byte goes to pointed register
// - Further data bytes go to advancing pointer
// - Reads return register at stored pointer
// - Pointer advances after read like writes
// - Advance stays within the register's group
// - Bit after address: zero write, one read
// - Fixed pointers hold, intensity group 10..13 wraps
// - Writes to input level register are dropped
`timescale 1ns/10ps
`default_nettype none
module i2c_pointer_slave
  import expander_i2c_pkg::*;
(
  input  wire logic                 CLK_I,
  input  wire logic                 RST_N_I,
  input  wire logic                 SCL_I,
  input  wire logic                 SDA_I,
  output logic                      SDA_O,
  output logic                      SDA_OE_O,
  input  wire logic [1:0]           ADDRESS_STRAP_HIGH_I,
  input  wire logic [1:0]           ADDRESS_STRAP_MID_I,
  input  wire logic [1:0]           ADDRESS_STRAP_LOW_I,
  output logic [SLAVE_ADDR_W-1:0]   SLAVE_ADDR_O,
  output logic [PTR_W-1:0]          PTR_O,
  input  wire logic [BYTE_W-1:0]    RD_DATA_I,
  output logic                      WR_VALID_O,
  output logic [PTR_W-1:0]          WR_ADDR_O,
  output logic [BYTE_W-1:0]         WR_DATA_O,
  input  wire logic                 WR_READY_I
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_CMD, ST_WDATA, ST_ACK, ST_RDATA, ST_RACK,
    ST_IGNORE
  } state_e;

  // Two-flop synchronisers plus one history stage for edges
  logic [1:0] scl_sync_r;
  logic [1:0] sda_sync_r;
  logic [5:0] strap_s1_r;
  logic [5:0] strap_s2_r;
  logic       scl_d_r;
  logic       sda_d_r;
  logic       scl_s;
  logic       sda_s;
  logic       scl_rise;
  logic       scl_fall;
  logic       bus_start;
  logic       bus_stop;

  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
      strap_s1_r <= 6'h00;
      strap_s2_r <= 6'h00;
      scl_d_r    <= 1'b1;
      sda_d_r    <= 1'b1;
    end
    else
    begin
      scl_sync_r <= {scl_sync_r[0], SCL_I};
      sda_sync_r <= {sda_sync_r[0], SDA_I};
      strap_s1_r <= {ADDRESS_STRAP_HIGH_I, ADDRESS_STRAP_MID_I,
                     ADDRESS_STRAP_LOW_I};
      strap_s2_r <= strap_s1_r;
      scl_d_r    <= scl_sync_r[1];
      sda_d_r    <= sda_sync_r[1];
    end
  end

  assign scl_s     = scl_sync_r[1];
  assign sda_s     = sda_sync_r[1];
  assign scl_rise  = scl_s && !scl_d_r;
  assign scl_fall  = !scl_s && scl_d_r;
  assign bus_start = scl_s && scl_d_r && sda_d_r && !sda_s;
  assign bus_stop  = scl_s && scl_d_r && !sda_d_r && sda_s;

  logic [SLAVE_ADDR_W-1:0] addr_dec;

  strap_addr_decode u_decode (
    .strap_high_i (strap_s2_r[5:4]),
    .strap_mid_i  (strap_s2_r[3:2]),
    .strap_low_i  (strap_s2_r[1:0]),
    .slave_addr_o (addr_dec)
  );

  logic                 fifo_push;
  logic                 fifo_ready;
  logic [WR_WORD_W-1:0] fifo_out;

  state_e              state_r;
  state_e              state_nxt;
  state_e              after_r;
  state_e              after_nxt;
  logic [7:0]          shift_r;
  logic [7:0]          shift_nxt;
  logic [3:0]          cnt_r;
  logic [3:0]          cnt_nxt;
  logic [PTR_W-1:0]    ptr_r;
  logic [PTR_W-1:0]    ptr_nxt;
  logic                oe_r;
  logic                oe_nxt;
  logic [SLAVE_ADDR_W-1:0] addr_r;
  logic [SLAVE_ADDR_W-1:0] addr_nxt;
  logic                byte_done;
  logic                cmd_load;
  logic                rd_load;

  always_comb
  begin
    state_nxt = state_r;
    after_nxt = after_r;
    shift_nxt = shift_r;
    cnt_nxt   = cnt_r;
    ptr_nxt   = ptr_r;
    oe_nxt    = oe_r;
    fifo_push = 1'b0;
    cmd_load  = 1'b0;
    rd_load   = 1'b0;
    // Straps only follow while idle, so a frame sees one address
    addr_nxt  = (state_r == ST_IDLE) ? addr_dec : addr_r;
    byte_done = scl_fall && (cnt_r == BITS_PER_BYTE);
    if (bus_start)
    begin
      // Repeated start keeps the stored pointer for the read
      state_nxt = ST_ADDR;
      cnt_nxt   = 4'h0;
      oe_nxt    = 1'b0;
    end
    else if (bus_stop)
    begin
      // Nothing beyond the stored pointer and the queued writes survives a stop
      state_nxt = ST_IDLE;
      oe_nxt    = 1'b0;
    end
    else
    begin
      unique case (state_r)
        ST_IDLE, ST_IGNORE:
        begin
          oe_nxt = 1'b0;
        end
        ST_ADDR, ST_CMD, ST_WDATA:
        begin
          if (scl_rise && cnt_r != BITS_PER_BYTE)
          begin
            shift_nxt = {shift_r[6:0], sda_s};
            cnt_nxt   = cnt_r + 4'h1;
          end
          else if (byte_done)
          begin
            cnt_nxt   = 4'h0;
            state_nxt = ST_ACK;
            oe_nxt    = 1'b1;
            if (state_r == ST_ADDR)
            begin
              if (shift_r[7:1] != addr_r)
              begin
                state_nxt = ST_IGNORE;
                oe_nxt    = 1'b0;
              end
              else
                after_nxt = shift_r[0] ? ST_RDATA : ST_CMD;
            end
            else if (state_r == ST_CMD)
            begin
              ptr_nxt   = shift_r;
              cmd_load  = 1'b1;
              after_nxt = ST_WDATA;
            end
            else if (ptr_r == PTR_INPUTS)
              after_nxt = ST_WDATA;
            else if (fifo_ready)
            begin
              fifo_push = 1'b1;
              ptr_nxt   = next_ptr(ptr_r);
              after_nxt = ST_WDATA;
            end
            else
            begin
              // Full buffer refuses the byte with a missing acknowledge
              state_nxt = ST_IGNORE;
              oe_nxt    = 1'b0;
            end
          end
        end
        ST_ACK:
        begin
          if (scl_fall)
          begin
            if (after_r == ST_RDATA)
            begin
              rd_load   = 1'b1;
              shift_nxt = RD_DATA_I;
              oe_nxt    = !RD_DATA_I[7];
              cnt_nxt   = 4'h1;
            end
            else
              oe_nxt = 1'b0;
            state_nxt = after_r;
          end
        end
        ST_RDATA:
        begin
          if (byte_done)
          begin
            oe_nxt    = 1'b0;
            state_nxt = ST_RACK;
          end
          else if (scl_fall)
          begin
            shift_nxt = {shift_r[6:0], 1'b0};
            oe_nxt    = !shift_r[6];
            cnt_nxt   = cnt_r + 4'h1;
          end
        end
        ST_RACK:
        begin
          if (scl_rise)
          begin
            ptr_nxt   = next_ptr(ptr_r);
            state_nxt = sda_s ? ST_IGNORE : ST_ACK;
            after_nxt = ST_RDATA;
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      state_r <= ST_IDLE;
      after_r <= ST_IDLE;
      shift_r <= 8'h00;
      cnt_r   <= 4'h0;
      ptr_r   <= PTR_RESET;
      oe_r    <= 1'b0;
      addr_r  <= '0;
      SDA_O   <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      after_r <= after_nxt;
      shift_r <= shift_nxt;
      cnt_r   <= cnt_nxt;
      ptr_r   <= ptr_nxt;
      oe_r    <= oe_nxt;
      addr_r  <= addr_nxt;
      SDA_O   <= 1'b0;
    end
  end

  write_fifo #(
    .W     (WR_WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (CLK_I),
    .rst_n_i     (RST_N_I),
    .in_valid_i  (fifo_push),
    .in_data_i   ({ptr_r, shift_r}),
    .in_ready_o  (fifo_ready),
    .out_valid_o (WR_VALID_O),
    .out_data_o  (fifo_out),
    .out_ready_i (WR_READY_I)
  );

  assign WR_ADDR_O    = fifo_out[WR_WORD_W-1:BYTE_W];
  assign WR_DATA_O    = fifo_out[BYTE_W-1:0];
  assign SDA_OE_O     = oe_r;
  assign PTR_O        = ptr_r;
  assign SLAVE_ADDR_O = addr_r;

  AST_CMD_LOADS_PTR: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    cmd_load |=> ptr_r == $past(shift_r))
    else $error("command byte not stored as pointer");

  AST_PUSH_USES_PTR: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    fifo_push |=> ptr_r == next_ptr($past(ptr_r)) ##0 oe_r)
    else $error("data byte did not advance pointer or ack");

  AST_NO_INPUT_WRITE: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    fifo_push |-> ptr_r != PTR_INPUTS)
    else $error("write to input level register was passed on");

  AST_GROUP_CONFINED: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    ($changed(ptr_r) && !$past(cmd_load))
      |-> (ptr_r >= PTR_GRP_FIRST && ptr_r <= PTR_GRP_LAST))
    else $error("pointer advanced outside its group");

  AST_WRAP_TO_FIRST: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    (state_r == ST_RACK && scl_rise && ptr_r == PTR_GRP_LAST)
      |=> ptr_r == PTR_GRP_FIRST)
    else $error("last intensity pointer did not wrap");

  AST_READ_SOURCE: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    rd_load |=> shift_r == $past(RD_DATA_I) && oe_r == !shift_r[7])
    else $error("read byte not taken from pointed register");

  AST_READ_ADVANCE: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    (state_r == ST_RACK && scl_rise) |=> ptr_r == next_ptr($past(ptr_r)))
    else $error("pointer not advanced after read byte");

  AST_FOREIGN_SILENT: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    (state_r == ST_IGNORE) |-> !oe_r && !fifo_push)
    else $error("device answered a foreign address");

  AST_STOP_ENDS: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    bus_stop |=> state_r == ST_IDLE && !oe_r && ptr_r == $past(ptr_r))
    else $error("stop did not end the transfer quietly");

  AST_ADDR_FOUR_FIVE: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    (state_r != ST_IDLE) |-> addr_r[4] != addr_r[5])
    else $error("address bit four is not inverse of bit five");

  COV_WRITE_DATA: cover property (
    @(posedge CLK_I) disable iff (!RST_N_I) fifo_push);
  COV_READ_BYTE: cover property (
    @(posedge CLK_I) disable iff (!RST_N_I) rd_load);
  COV_REPEATED_START: cover property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    bus_start && state_r == ST_WDATA);

endmodule : i2c_pointer_slave
`default_nettype wire

// File: hdl/strap_addr_decode.sv
// Slave address decode from the three four-state address straps
`timescale 1ns/10ps
`default_nettype none
module strap_addr_decode
  import expander_i2c_pkg::*;
(
  input  wire logic [1:0] strap_high_i,
  input  wire logic [1:0] strap_mid_i,
  input  wire logic [1:0] strap_low_i,
  output logic      [6:0] slave_addr_o
);

  function automatic logic on_bus(input logic [1:0] s);
    return (s == STRAP_SCL) || (s == STRAP_SDA);
  endfunction : on_bus

  function automatic logic is_high(input logic [1:0] s);
    return (s == STRAP_VDD) || (s == STRAP_SDA);
  endfunction : is_high

  logic slave_addr_bit_six;
  logic slave_addr_bit_five;
  logic slave_addr_bit_four;
  logic slave_addr_bit_three;
  logic slave_addr_bit_two;
  logic slave_addr_bit_one;
  logic slave_addr_bit_zero;

  always_comb
  begin
    slave_addr_bit_six   = on_bus(strap_high_i);
    slave_addr_bit_five  = !on_bus(strap_mid_i);
    slave_addr_bit_four  = !slave_addr_bit_five;
    slave_addr_bit_three = on_bus(strap_low_i);
    slave_addr_bit_two   = is_high(strap_high_i);
    slave_addr_bit_one   = is_high(strap_mid_i);
    slave_addr_bit_zero  = is_high(strap_low_i);
    slave_addr_o = {slave_addr_bit_six, slave_addr_bit_five,
                    slave_addr_bit_four, slave_addr_bit_three,
                    slave_addr_bit_two, slave_addr_bit_one,
                    slave_addr_bit_zero};
  end

endmodule : strap_addr_decode
`default_nettype wire

// File: hdl/write_fifo.sv
// Write-data FIFO with a registered output stage
`timescale 1ns/10ps
`default_nettype none
module write_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 8
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         in_valid_i,
  input  wire logic [W-1:0] in_data_i,
  output logic              in_ready_o,
  output logic              out_valid_o,
  output logic      [W-1:0] out_data_o,
  input  wire logic         out_ready_i
);

  // DEPTH must be a power of two for the wrap bit to work
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_r [DEPTH];
  logic [AW:0]  wp_r;
  logic [AW:0]  wp_nxt;
  logic [AW:0]  rp_r;
  logic [AW:0]  rp_nxt;
  logic         ov_r;
  logic         ov_nxt;
  logic [W-1:0] od_r;
  logic [W-1:0] od_nxt;
  logic         full;
  logic         empty;
  logic         push;
  logic         load;

  always_comb
  begin
    full  = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
    empty = (wp_r == rp_r);
    in_ready_o = !full;
    push   = in_valid_i && !full;
    load   = !empty && (!ov_r || out_ready_i);
    wp_nxt = push ? wp_r + 1'b1 : wp_r;
    rp_nxt = load ? rp_r + 1'b1 : rp_r;
    ov_nxt = load ? 1'b1 : (out_ready_i ? 1'b0 : ov_r);
    od_nxt = load ? mem_r[rp_r[AW-1:0]] : od_r;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wp_r <= '0;
      rp_r <= '0;
      ov_r <= 1'b0;
      od_r <= '0;
    end
    else
    begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      ov_r <= ov_nxt;
      od_r <= od_nxt;
    end
  end

  // Storage needs no reset, only the pointers and the output stage do
  always_ff @(posedge clk_i)
  begin
    if (push)
      mem_r[wp_r[AW-1:0]] <= in_data_i;
  end

  assign out_valid_o = ov_r;
  assign out_data_o  = od_r;

endmodule : write_fifo
`default_nettype wire

// File: test/i2c_master_model.sv
// Behavioural bus master that drives the serial clock and data pins
`timescale 1ns/10ps
`default_nettype none
module i2c_master_model
(
  input  wire logic clk_i,
  input  wire logic sda_i,
  output var  logic scl_o,
  output var  logic sda_o
);
  // Both lines released; the clock stands still between frames
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick

  // Entered two cycles into a low phase, or from an idle bus
  task automatic start();
    sda_o <= 1'b1;
    tick(2);
    scl_o <= 1'b1;
    tick(4);
    sda_o <= 1'b0;
    tick(4);
    scl_o <= 1'b0;
    tick(2);
  endtask : start

  // Data moves mid low phase so it is settled before the clock rises
  task automatic bit_io(input logic b, output logic got);
    sda_o <= b;
    tick(2);
    scl_o <= 1'b1;
    tick(4);
    got = sda_i;
    scl_o <= 1'b0;
    tick(2);
  endtask : bit_io

  task automatic send(input logic [7:0] d, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], g);
    bit_io(1'b1, ack);
  endtask : send

  task automatic recv(input logic nack, output logic [7:0] d);
    logic g;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, d[i]);
    bit_io(nack, g);
  endtask : recv

  task automatic address(input logic [6:0] a, input logic rd,
                         output logic ack);
    start();
    send({a, rd}, ack);
  endtask : address

  task automatic stop();
    sda_o <= 1'b0;
    tick(2);
    scl_o <= 1'b1;
    tick(4);
    sda_o <= 1'b1;
    tick(6);
  endtask : stop
endmodule : i2c_master_model
`default_nettype wire

// File: test/tb_i2c_slave_pointer_access.sv
// Self-checking bench for the pointer-access serial slave
`timescale 1ns/10ps
`default_nettype none
module tb_i2c_slave_pointer_access
  import expander_i2c_pkg::*;
;
  localparam logic [6:0] MY_ADDR = 7'h1d;
  logic        clk;
  logic        rst_n;
  logic        scl;
  logic        m_sda;
  logic        sda_o;
  logic        sda_oe;
  logic [1:0]  st_hi, st_mid, st_lo;
  logic [6:0]  saddr;
  logic [7:0]  ptr, rd_data, wr_addr, wr_data;
  logic        wr_valid, wr_ready;
  logic [7:0]  regs [256];
  logic [15:0] log_q [$];
  int          miscompares;
  int          n_checks;
  // Pull-up on the data line; the slave can only pull it low
  wire logic   sda_line = m_sda & (~sda_oe | sda_o);

  always #12.5 clk = ~clk;

  i2c_master_model m_u (
    .clk_i (clk),
    .sda_i (sda_line),
    .scl_o (scl),
    .sda_o (m_sda)
  );

  i2c_pointer_slave dut_u (
    .CLK_I                (clk),
    .RST_N_I              (rst_n),
    .SCL_I                (scl),
    .SDA_I                (sda_line),
    .SDA_O                (sda_o),
    .SDA_OE_O             (sda_oe),
    .ADDRESS_STRAP_HIGH_I (st_hi),
    .ADDRESS_STRAP_MID_I  (st_mid),
    .ADDRESS_STRAP_LOW_I  (st_lo),
    .SLAVE_ADDR_O         (saddr),
    .PTR_O                (ptr),
    .RD_DATA_I            (rd_data),
    .WR_VALID_O           (wr_valid),
    .WR_ADDR_O            (wr_addr),
    .WR_DATA_O            (wr_data),
    .WR_READY_I           (wr_ready)
  );

  // Register file behind the write queue
  always @(posedge clk)
  begin
    rd_data <= regs[ptr];
    if (wr_valid && wr_ready)
    begin
      log_q.push_back({wr_addr, wr_data});
      regs[wr_addr] <= wr_data;
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude

  // Bounded wait for n queued writes; a shortfall ends the run
  task automatic drain(input int n);
    for (int i = 0; i < 60 && log_q.size() < n; i++)
      @(posedge clk);
    repeat (4) @(posedge clk);
    check(16'(log_q.size()), 16'(n));
    if (log_q.size() < n)
      conclude();
  endtask : drain

  task automatic wr_frame(input logic [7:0] cmd, input logic [7:0] d0,
                          input int n, input int nacc);
    logic a;
    m_u.address(MY_ADDR, 1'b0, a);
    check(16'(a), 16'h0);
    m_u.send(cmd, a);
    check(16'(a), 16'h0);
    for (int k = 0; k < n; k++)
    begin
      m_u.send(d0 + 8'(k * 17), a);
      check(16'(a), 16'(k >= nacc));
    end
    m_u.stop();
  endtask : wr_frame

  task automatic t_addr();
    logic [6:0] e;
    // Literal rows of the address map, independent of the strap coding
    logic [5:0] rows [4] = '{6'h08, 6'h3f, 6'h28, 6'h37};
    logic [6:0] want [4] = '{7'h10, 7'h5f, 7'h50, 7'h6f};
    for (int k = 0; k < 64; k++)
    begin
      st_hi <= k[5:4];
      st_mid <= k[3:2];
      st_lo <= k[1:0];
      repeat (8) @(posedge clk);
      e = {st_hi[1], ~st_mid[1], st_mid[1], st_lo[1],
           st_hi[0], st_mid[0], st_lo[0]};
      check(16'(saddr), 16'(e));
    end
    foreach (rows[j])
    begin
      st_hi <= rows[j][5:4];
      st_mid <= rows[j][3:2];
      st_lo <= rows[j][1:0];
      repeat (8) @(posedge clk);
      check(16'(saddr), 16'(want[j]));
    end
    st_hi <= 2'h1;
    st_mid <= 2'h2;
    st_lo <= 2'h3;
    repeat (8) @(posedge clk);
    check(16'(saddr), 16'(MY_ADDR));
    $display("address decode done");
  endtask : t_addr

  task automatic t_cmd_only();
    log_q.delete();
    wr_frame(8'h12, 8'h00, 0, 0);
    repeat (8) @(posedge clk);
    check(16'(ptr), 16'h12);
    check(16'(log_q.size()), 16'h0);
    $display("command only done");
  endtask : t_cmd_only

  // Consumer stalls: nine bytes fit, the tenth is refused
  task automatic t_fill();
    log_q.delete();
    wr_ready <= 1'b0;
    wr_frame(8'h10, 8'h30, 10, 9);
    check(16'(ptr), 16'h11);
    wr_ready <= 1'b1;
    drain(9);
    for (int k = 0; k < 9; k++)
      check(log_q[k], {8'h10 + 8'(k % 4), 8'h30 + 8'(k * 17)});
    $display("burst and fill done");
  endtask : t_fill

  task automatic t_hold();
    logic [7:0] fixed [6] = '{8'h00, 8'h01, 8'h03, 8'h09, 8'h0e, 8'h0f};
    foreach (fixed[i])
    begin
      log_q.delete();
      wr_frame(fixed[i], 8'ha0, 2, 2);
      drain((fixed[i] == 8'h00) ? 0 : 2);
      check(16'(ptr), 16'(fixed[i]));
      foreach (log_q[k])
        check(log_q[k], {fixed[i], 8'ha0 + 8'(k * 17)});
    end
    $display("fixed pointers done");
  endtask : t_hold

  task automatic t_read();
    logic       a;
    logic [7:0] d;
    logic [7:0] idx [3] = '{8'h13, 8'h10, 8'h11};
    m_u.address(MY_ADDR, 1'b0, a);
    m_u.send(8'h13, a);
    m_u.address(MY_ADDR, 1'b1, a);
    check(16'(a), 16'h0);
    foreach (idx[k])
    begin
      m_u.recv(k == 2, d);
      check(16'(d), 16'(regs[idx[k]]));
    end
    m_u.stop();
    check(16'(ptr), 16'h12);
    $display("read done");
  endtask : t_read

  task automatic t_foreign();
    logic a;
    log_q.delete();
    m_u.address(MY_ADDR ^ 7'h01, 1'b0, a);
    check(16'(a), 16'h1);
    m_u.send(8'h05, a);
    check(16'(a), 16'h1);
    m_u.stop();
    check(16'(ptr), 16'h12);
    check(16'(log_q.size()), 16'h0);
    $display("foreign address done");
  endtask : t_foreign

  initial
  begin
    repeat (80000) @(posedge clk);
    miscompares++;
    conclude();
  end

  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    wr_ready = 1'b1;
    st_hi = 2'h1;
    st_mid = 2'h2;
    st_lo = 2'h3;
    miscompares = 0;
    n_checks = 0;
    for (int i = 0; i < 256; i++)
      regs[i] = 8'(i) ^ 8'h5a;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    check(16'(ptr), 16'(PTR_RESET));
    t_addr();
    t_cmd_only();
    t_fill();
    t_hold();
    t_read();
    t_foreign();
    conclude();
  end
endmodule : tb_i2c_slave_pointer_access
`default_nettype wire
